// file: tb/pie_peer.sv
// Far-side model: peripheral request lines and the accepting CPU
module pie_peer (
   // Clock
   input  wire logic        clk_in,
   // Commands from the bench and the encoder's request
   input  wire logic [33:0] set_in,
   input  wire logic        nmi_set_in,
   input  wire logic        take_in,
   input  wire logic        cpu_req_out,
   // Lines into the encoder
   output logic      [33:0] src_req_out = '0,
   output logic             nmi_out = 1'b0,
   output logic             accept_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Sources hold their level until the bench drops them
   always @(posedge clk_in) begin
      src_req_out <= set_in;
      nmi_out <= nmi_set_in;
   end
   // Accept only what is presented, and never twice in a row
   always @(posedge clk_in) begin
      accept_out <= take_in && cpu_req_out && !accept_out;
   end
endmodule

// file: tb/pie_sva.sv
// Port-level assertions for the interrupt priority encoder
module pie_sva
   import pie_pkg::*;
#(
   parameter int NUM_SRC = 34
) (
   // Clock and reset
   input wire logic               clk_in,
   input wire logic               nrst_in,
   // Bus and request side
   input wire logic               wb_cyc_in,
   input wire logic               wb_stb_in,
   input wire logic               wb_ack_out,
   input wire logic [NUM_SRC-1:0] src_req_in,
   input wire logic               nmi_req_in,
   // CPU side
   input wire logic [3:0]         mask_level_bits_in,
   input wire logic               standby_in,
   input wire logic               osc32k_used_in,
   input wire logic               cpu_req_out,
   input wire logic [4:0]         cpu_level_out,
   input wire logic               wake_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   a_req_above_mask: assert property (cpu_req_out |-> cpu_level_out > mask_level_bits_in)
      else $error("request presented at or below mask");
   a_level_gives_req: assert property (cpu_level_out > mask_level_bits_in |-> cpu_req_out)
      else $error("level above mask not presented");
   a_zero_level_idle: assert property (cpu_level_out == 5'h00 |-> !cpu_req_out)
      else $error("request with no level");
   // Four samples cover the two-stage synchroniser
   a_nmi_top_level: assert property (nmi_req_in [*4] |-> cpu_req_out && cpu_level_out == 5'h10)
      else $error("nonmaskable request not at top level");
   a_debug_fixed: assert property (src_req_in[0] [*4] |-> cpu_level_out >= 5'h0F)
      else $error("debug request below fixed level");
   a_wake_gated: assert property (wake_out |-> standby_in && osc32k_used_in)
      else $error("wake outside standby with slow oscillator");
   a_reset_quiet: assert property ($rose(nrst_in) |-> !cpu_req_out [*2])
      else $error("request right after reset");
   a_ack_single: assert property ($rose(wb_cyc_in && wb_stb_in) |=> wb_ack_out ##1 !wb_ack_out)
      else $error("bus answer not a single cycle");
endmodule
bind pie_top pie_sva #(.NUM_SRC(NUM_SRC)) u_sva (.clk_in(clk_in), .nrst_in(nrst_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
   .src_req_in(src_req_in), .nmi_req_in(nmi_req_in), .mask_level_bits_in(mask_level_bits_in),
   .standby_in(standby_in), .osc32k_used_in(osc32k_used_in), .cpu_req_out(cpu_req_out),
   .cpu_level_out(cpu_level_out), .wake_out(wake_out));

// file: tb/testbench.sv
// Self-checking bench for the interrupt priority encoder
module testbench
   import pie_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_in = 1'b0, nrst_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        nmi_set = 1'b0, take = 1'b0, standby = 1'b0, osc = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  mask = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rd, rdat;
   logic [33:0] set = 34'h0_0000_0000, req, rv;
   logic        nmi, acc, cpu_req, wake, irq, ack;
   logic [4:0]  lvl;
   int          errors = 0, checked = 0, pr[5], x;
   pie_top u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .src_req_in(req), .nmi_req_in(nmi), .mask_level_bits_in(mask),
      .cpu_accept_in(acc), .standby_in(standby), .osc32k_used_in(osc), .cpu_req_out(cpu_req),
      .cpu_level_out(lvl), .wake_out(wake), .irq_out(irq));
   pie_peer u_peer (.clk_in(clk_in), .set_in(set), .nmi_set_in(nmi_set), .take_in(take),
      .cpu_req_out(cpu_req), .src_req_out(req), .nmi_out(nmi), .accept_out(acc));
   task automatic results();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk_in);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      if (n >= 20) begin errors++; results(); end
      if (w && a <= 8'h10) pr[a/4] = d[15:0];
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, rd);
   endtask
   // Field of each source: register index times 16 plus bit offset
   function automatic int fr(int i);
      if (i == 0) return 0;
      if (i < 5) return 32 + (i - 1) * 4;
      if (i < 7) return 48 + (i - 5) * 4;
      if (i < 11) return 76;
      if (i < 15) return 68;
      if (i == 15) return 64;
      if (i < 19) return 12 - (i - 16) * 4;
      if (i == 19) return 4;
      if (i < 23) return 0;
      if (i < 27) return 20;
      if (i == 27) return 28;
      if (i < 30) return 24;
      return i < 32 ? 56 : 60;
   endfunction
   function automatic int lvm(int i);
      return i == 0 ? 15 : (pr[fr(i) / 16] >> (fr(i) % 16)) & 15;
   endfunction
   function automatic int sc(int i);
      if (i == 0) return 'h5E0;
      if (i < 7) return 'h600 + (i - 1) * 32;
      if (i < 11) return 'h800 + (i - 7) * 32;
      if (i < 16) return 'h900 + (i - 11) * 32;
      return i < 30 ? 'h400 + (i - 16) * 32 : 0;
   endfunction
   function automatic int best(logic [33:0] r);
      int b;
      b = -1;
      for (int i = 0; i < 34; i++)
         if (r[i] && lvm(i) > 0 && (b < 0 || lvm(i) > lvm(b))) b = i;
      return b;
   endfunction
   task automatic run(input logic [33:0] r, input logic [3:0] m);
      int b, el, pc;
      set <= r; mask <= m;
      repeat (4) @(posedge clk_in);
      b = best(r);
      el = nmi_set ? 16 : (b < 0 ? 0 : lvm(b));
      pc = (b == 0 || b > 15 && b < 30) ? sc(b) : 'h200 + (15 - el) * 32;
      chk("level", el, {27'h0, lvl});
      chk("cpu_req", el > m, {31'h0, cpu_req});
      if (el > m) begin
         take <= 1'b1;
         @(posedge clk_in);
         take <= 1'b0;
         repeat (2) @(posedge clk_in);
         wb(1'b0, 8'h14, 32'h0, rd);
         chk("primary", nmi_set ? 'h1C0 : pc, rd);
         wb(1'b0, 8'h18, 32'h0, rd);
         chk("secondary", nmi_set ? 'h1C0 : sc(b), rd);
      end
      set <= 34'h0;
      repeat (4) @(posedge clk_in);
   endtask
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   initial begin
      repeat (90000) @(posedge clk_in);
      errors++;
      results();
   end
   initial begin
      x = $urandom(32'h2a7f);
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      for (int a = 0; a < 5; a++) begin
         wb(1'b0, a * 4, 32'h0, rd);
         chk("reset", 32'h0, rd);
      end
      wb(1'b0, 8'h30, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      for (int i = 0; i < 34; i++) begin
         for (int a = 0; a < 5; a++) wr(a * 4, 32'h0);
         x = fr(i);
         if (i > 0) wr(x / 16 * 4, $urandom_range(15, 1) << (x % 16));
         wb(1'b0, x / 16 * 4, 32'h0, rd);
         chk("readback", pr[x / 16], rd);
         run(34'h1 << i, 4'h0);
      end
      for (int a = 0; a < 5; a++) wr(a * 4, 32'h0000_5555);
      run(34'h0_0000_0280, 4'h0);
      run(34'h0_0000_3000, 4'h0);
      run(34'h0_1000_8002, 4'h0);
      run(34'h0_0001_0000, 4'h5);
      nmi_set <= 1'b1;
      run(34'h0_0000_0002, 4'hF);
      nmi_set <= 1'b0;
      wb(1'b0, 8'h20, 32'h0, rd);
      wr(8'h24, 32'h0000_0001);
      wr(8'h1C, 32'h0000_00FF);
      run(34'h0_0001_0000, 4'h4);
      chk("irq_set", 32'h1, {31'h0, irq});
      wb(1'b0, 8'h20, 32'h0, rd);
      chk("status", 32'h1, {31'h0, rd[0]});
      chk("irq_clear", 32'h0, {31'h0, irq});
      wr(8'h24, 32'h0);
      run(34'h0_0001_0000, 4'h4);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(8'h00, 32'h0);
      run(34'h0_0001_0000, 4'h0);
      wr(8'h00, 32'h0000_5000);
      set <= 34'h0_0001_0000; mask <= 4'h3; standby <= 1'b1; osc <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk("wake", 32'h1, {31'h0, wake});
      osc <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk("wake_slow", 32'h0, {31'h0, wake});
      standby <= 1'b0; set <= 34'h0;
      for (int k = 0; k < 12; k++) begin
         for (int a = 0; a < 5; a++) wr(a * 4, $urandom);
         rv = {$urandom, $urandom};
         run(rv & ~34'h1, $urandom_range(15, 0));
      end
      results();
   end
endmodule

// file: verilog/pie_cfg.svh
// Register offsets, reset value, fixed levels, event codes and source count for the priority encoder
`ifndef PIE_CFG_SVH
`define PIE_CFG_SVH
`define PIE_ADDR_PRI_A   8'h00
`define PIE_ADDR_PRI_B   8'h04
`define PIE_ADDR_PRI_C   8'h08
`define PIE_ADDR_PRI_D   8'h0C
`define PIE_ADDR_PRI_E   8'h10
`define PIE_ADDR_EVT_PRI 8'h14
`define PIE_ADDR_EVT_SEC 8'h18
`define PIE_ADDR_CTRL    8'h1C
`define PIE_ADDR_IRQ_ST  8'h20
`define PIE_ADDR_IRQ_MSK 8'h24
`define PIE_PRI_RESET    16'h0000
`define PIE_LVL_MASKED   4'h0
`define PIE_LVL_DEBUG    5'h0F
`define PIE_LVL_NMI      5'h10
`define PIE_CODE_NMI     12'h1C0
`define PIE_CODE_DEBUG   12'h5E0
`define PIE_CODE_LVL15   12'h200
`define PIE_CODE_STEP    12'h020
`define PIE_CODE_IRQ0    12'h600
`define PIE_CODE_DMA0    12'h800
`define PIE_CODE_FIFO0   12'h900
`define PIE_CODE_CONV    12'h980
`define PIE_CODE_TMR0    12'h400
`define PIE_NUM_SRC      34
`endif

// file: verilog/pie_pkg.sv
// Types shared by the peripheral interrupt priority encoder
package pie_pkg;
   typedef enum logic [1:0] {
      PIE_BUS_IDLE,
      PIE_BUS_ACK
   } pie_bus_state_t;
   typedef logic [3:0]  pie_level_t;
   typedef logic [11:0] pie_code_t;
endpackage

// file: verilog/pie_top.sv
// Peripheral interrupt priority encoder with Wishbone register access
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`include "pie_cfg.svh"
module pie_top
   import pie_pkg::*;
#(
   parameter int NUM_SRC = `PIE_NUM_SRC
) (
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               nrst_in,
   // Wishbone slave
   input  wire logic               wb_cyc_in,
   input  wire logic               wb_stb_in,
   input  wire logic               wb_we_in,
   input  wire logic [7:0]         wb_adr_in,
   input  wire logic [3:0]         wb_sel_in,
   input  wire logic [31:0]        wb_dat_in,
   output logic      [31:0]        wb_dat_out,
   output logic                    wb_ack_out,
   // Request lines, index order is the default order
   input  wire logic [NUM_SRC-1:0] src_req_in,
   input  wire logic               nmi_req_in,
   // CPU side
   input  wire logic [3:0]         mask_level_bits_in,
   input  wire logic               cpu_accept_in,
   input  wire logic               standby_in,
   input  wire logic               osc32k_used_in,
   output logic                    cpu_req_out,
   output logic      [4:0]         cpu_level_out,
   output logic                    wake_out,
   output logic                    irq_out
);

   // Source indices, which are also the default order on equal levels:
   //    0      debug interface, level fixed
   //    1..4   request pins 0-3, fields of C
   //    5..6   request pins 4-5, low fields of D
   //    7..10  dma end, channels 0-3, E[15:12]
   //    11..14 fifo serial error, rx full, break, tx empty, E[7:4]
   //    15     conversion end, E[3:0]
   //    16..18 timer 0-2 underflow, A fields
   //    19     timer 2 capture, shares A[7:4]
   //    20..22 clock alarm, periodic, carry, A[3:0]
   //    23..26 plain serial error, rx, tx, tx end, B[7:4]
   //    27     watchdog interval, B[15:12]
   //    28..29 refresh match and overflow, B[11:8]
   //    30..33 port interrupt lanes, pairs on D[11:8] and D[15:12]

   // Register file
   logic [15:0]        priority_set_a;
   logic [15:0]        priority_set_b;
   logic [15:0]        priority_set_c;
   logic [15:0]        priority_set_d;
   logic [15:0]        priority_set_e;
   logic [11:0]        event_code_primary;
   logic [11:0]        event_code_secondary;
   logic [1:0]         ctrl_reg;
   logic [1:0]         irq_status;
   logic [1:0]         irq_mask;

   // Synchroniser stages
   logic [NUM_SRC-1:0] req_s1;
   logic [NUM_SRC-1:0] req_s2;
   logic               nmi_s1;
   logic               nmi_s2;

   // Per-source tables
   logic [3:0]         src_lvl  [NUM_SRC];
   pie_code_t          src_code [NUM_SRC];
   logic               src_lvl_based [NUM_SRC];
   logic [NUM_SRC-1:0] src_live;

   // Encoder results
   logic [4:0]         best_lvl;
   logic [5:0]         best_idx;
   logic               best_any;
   logic               wake_hit;
   logic               take;

   // Bus decode
   pie_bus_state_t     bus_state;
   logic               bus_req;
   logic               bus_wr;
   logic               bus_rd;
   logic               status_rd;

   // Next values
   pie_bus_state_t     next_bus_state;
   pie_code_t          next_code_primary;
   pie_code_t          next_code_secondary;
   logic [31:0]        next_rd_data;
   logic [1:0]         next_irq_status;

   // Pins and peripheral lines come from other domains
   // Two stages per line; only the second stage feeds any logic
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         req_s1 <= '0;
         req_s2 <= '0;
         nmi_s1 <= 1'b0;
         nmi_s2 <= 1'b0;
      end else begin
         req_s1 <= src_req_in;
         req_s2 <= req_s1;
         nmi_s1 <= nmi_req_in;
         nmi_s2 <= nmi_s1;
      end
   end

   // Level per source
   always_comb begin
      for (int i = 0; i < NUM_SRC; i++) begin
         src_lvl[i] = 4'h0;
      end
      src_lvl[0] = 4'(`PIE_LVL_DEBUG);
      for (int i = 0; i < 4; i++) begin
         src_lvl[1+i]  = priority_set_c[4*i +: 4];
         src_lvl[7+i]  = priority_set_e[15:12];
         src_lvl[11+i] = priority_set_e[7:4];
      end
      for (int i = 0; i < 2; i++) begin
         src_lvl[5+i] = priority_set_d[4*i +: 4];
      end
      src_lvl[15] = priority_set_e[3:0];
      src_lvl[16] = priority_set_a[15:12];
      src_lvl[17] = priority_set_a[11:8];
      src_lvl[18] = priority_set_a[7:4];
      src_lvl[19] = priority_set_a[7:4];
      for (int i = 20; i < 23; i++) begin
         src_lvl[i] = priority_set_a[3:0];
      end
      for (int i = 23; i < 27; i++) begin
         src_lvl[i] = priority_set_b[7:4];
      end
      src_lvl[27] = priority_set_b[15:12];
      src_lvl[28] = priority_set_b[11:8];
      src_lvl[29] = priority_set_b[11:8];
      // Port lanes take the upper D fields, two lanes to a field
      for (int i = 30; i < NUM_SRC; i++) begin
         src_lvl[i] = priority_set_d[8 + 4*((i-30)/2) +: 4];
      end
   end

   // Code per source; level-based ones report the level code first
   always_comb begin
      for (int i = 0; i < NUM_SRC; i++) begin
         src_code[i]      = 12'h000;
         src_lvl_based[i] = 1'b0;
      end
      src_code[0] = `PIE_CODE_DEBUG;
      for (int i = 0; i < 6; i++) begin
         src_code[1+i] = `PIE_CODE_IRQ0 + 12'(i) * `PIE_CODE_STEP;
      end
      for (int i = 0; i < 4; i++) begin
         src_code[7+i]  = `PIE_CODE_DMA0 + 12'(i) * `PIE_CODE_STEP;
         src_code[11+i] = `PIE_CODE_FIFO0 + 12'(i) * `PIE_CODE_STEP;
      end
      src_code[15] = `PIE_CODE_CONV;
      for (int i = 1; i < 16; i++) begin
         src_lvl_based[i] = 1'b1;
      end
      // Fixed-code peripherals, codes run contiguously from timer 0
      for (int i = 16; i < 30; i++) begin
         src_code[i] = `PIE_CODE_TMR0 + 12'(i-16) * `PIE_CODE_STEP;
      end
      // Port lane codes are left to the port block
      for (int i = 30; i < NUM_SRC; i++) begin
         src_lvl_based[i] = 1'b1;
      end
   end

   // Zero-level sources drop out here, so the encoder never sees them
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_live
      assign src_live[g] = req_s2[g] && (src_lvl[g] != `PIE_LVL_MASKED);
   end

   // Highest level wins; strict greater keeps lower index on ties
   always_comb begin
      best_lvl = 5'h00;
      best_idx = 6'h00;
      best_any = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (src_live[i] && {1'b0, src_lvl[i]} > best_lvl) begin
            best_lvl = {1'b0, src_lvl[i]};
            best_idx = 6'(i);
            best_any = 1'b1;
         end
      end
      if (nmi_s2) begin
         best_lvl = `PIE_LVL_NMI;
         best_any = 1'b1;
      end
   end

   // Wake only for timer and clock sources on the slow oscillator
   always_comb begin
      wake_hit = 1'b0;
      for (int i = 16; i < 23; i++) begin
         if (req_s2[i] && src_lvl[i] > mask_level_bits_in && osc32k_used_in
             && standby_in) begin
            wake_hit = 1'b1;
         end
      end
   end

   // Mask level is only read, never driven back
   // Combinational, so an accept in this cycle sees the current winner
   assign cpu_req_out   = best_any && (best_lvl > {1'b0, mask_level_bits_in});
   assign cpu_level_out = best_any ? best_lvl : 5'h00;
   assign wake_out      = wake_hit;
   assign take          = cpu_req_out && cpu_accept_in;

   // One vector for all; the code registers let software find the source
   always_comb begin
      next_code_primary   = event_code_primary;
      next_code_secondary = event_code_secondary;
      if (take) begin
         if (nmi_s2) begin
            next_code_primary   = `PIE_CODE_NMI;
            next_code_secondary = `PIE_CODE_NMI;
         end else if (src_lvl_based[best_idx]) begin
            next_code_primary   = `PIE_CODE_LVL15
                                  + 12'(5'h0F - best_lvl) * `PIE_CODE_STEP;
            next_code_secondary = src_code[best_idx];
         end else begin
            next_code_primary   = src_code[best_idx];
            next_code_secondary = src_code[best_idx];
         end
      end
   end

   // Codes stand until the next take, so a slow handler still reads its own source
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         event_code_primary   <= 12'h000;
         event_code_secondary <= 12'h000;
      end else begin
         event_code_primary   <= next_code_primary;
         event_code_secondary <= next_code_secondary;
      end
   end

   // Wishbone classic: ack one cycle after strobe, dropped the next cycle
   assign bus_req = wb_cyc_in && wb_stb_in && (bus_state == PIE_BUS_IDLE);
   assign bus_wr  = bus_req && wb_we_in;
   assign bus_rd  = bus_req && !wb_we_in;

   always_comb begin
      case (bus_state)
         PIE_BUS_IDLE: begin
            next_bus_state = bus_req ? PIE_BUS_ACK : PIE_BUS_IDLE;
         end
         PIE_BUS_ACK: begin
            next_bus_state = PIE_BUS_IDLE;
         end
         default: begin
            next_bus_state = PIE_BUS_IDLE;
         end
      endcase
   end

   // Ack is a registered copy of the accepted strobe: one wait state per access,
   // and the busy state keeps a held strobe from being taken twice
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bus_state  <= PIE_BUS_IDLE;
         wb_ack_out <= 1'b0;
      end else begin
         bus_state  <= next_bus_state;
         wb_ack_out <= bus_req;
      end
   end

   // Priority registers, byte lanes 0 and 1 only
   // Upper lanes are ignored because every priority register is 16 bits wide
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         priority_set_a <= `PIE_PRI_RESET;
         priority_set_b <= `PIE_PRI_RESET;
         priority_set_c <= `PIE_PRI_RESET;
         priority_set_d <= `PIE_PRI_RESET;
         priority_set_e <= `PIE_PRI_RESET;
         ctrl_reg       <= 2'b00;
         irq_mask       <= 2'b00;
      end else if (bus_wr) begin
         for (int b = 0; b < 2; b++) begin
            if (wb_sel_in[b]) begin
               case (wb_adr_in)
                  `PIE_ADDR_PRI_A: priority_set_a[8*b +: 8] <= wb_dat_in[8*b +: 8];
                  `PIE_ADDR_PRI_B: priority_set_b[8*b +: 8] <= wb_dat_in[8*b +: 8];
                  `PIE_ADDR_PRI_C: priority_set_c[8*b +: 8] <= wb_dat_in[8*b +: 8];
                  `PIE_ADDR_PRI_D: priority_set_d[8*b +: 8] <= wb_dat_in[8*b +: 8];
                  `PIE_ADDR_PRI_E: priority_set_e[8*b +: 8] <= wb_dat_in[8*b +: 8];
                  default: ;
               endcase
            end
         end
         if (wb_sel_in[0] && wb_adr_in == `PIE_ADDR_IRQ_MSK) begin
            irq_mask <= wb_dat_in[1:0];
         end
         if (wb_sel_in[0] && wb_adr_in == `PIE_ADDR_CTRL) begin
            ctrl_reg <= wb_dat_in[1:0];
         end
      end
   end

   // Sticky events: bit0 request taken, bit1 wake; set beats read-clear
   // The set term is ORed last, so an event in the clearing cycle is kept
   assign status_rd = bus_rd && (wb_adr_in == `PIE_ADDR_IRQ_ST);

   always_comb begin
      next_irq_status = irq_status;
      if (status_rd) begin
         next_irq_status = 2'b00;
      end
      next_irq_status = next_irq_status | {wake_hit, take};
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_status <= 2'b00;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   // Enable bits let software keep a status bit without raising the line
   assign irq_out = |(irq_status & irq_mask & ctrl_reg);

   // Read mux; unmapped offsets read as zero
   always_comb begin
      case (wb_adr_in)
         `PIE_ADDR_PRI_A:   next_rd_data = {16'h0000, priority_set_a};
         `PIE_ADDR_PRI_B:   next_rd_data = {16'h0000, priority_set_b};
         `PIE_ADDR_PRI_C:   next_rd_data = {16'h0000, priority_set_c};
         `PIE_ADDR_PRI_D:   next_rd_data = {16'h0000, priority_set_d};
         `PIE_ADDR_PRI_E:   next_rd_data = {16'h0000, priority_set_e};
         `PIE_ADDR_EVT_PRI: next_rd_data = {20'h0_0000, event_code_primary};
         `PIE_ADDR_EVT_SEC: next_rd_data = {20'h0_0000, event_code_secondary};
         `PIE_ADDR_CTRL:    next_rd_data = {30'h0000_0000, ctrl_reg};
         `PIE_ADDR_IRQ_ST:  next_rd_data = {30'h0000_0000, irq_status};
         `PIE_ADDR_IRQ_MSK: next_rd_data = {30'h0000_0000, irq_mask};
         default:           next_rd_data = 32'h0000_0000;
      endcase
   end

   // Read data is registered and held until the next read of any register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else if (bus_rd) begin
         wb_dat_out <= next_rd_data;
      end
   end

endmodule
